// ==== tb/watchdog_timeout_unit_assertions.sv ====
/* Port assertions for the watchdog time-out unit.
   Assumes it is bound into watchdog_timeout_unit. */
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module watchdog_timeout_unit_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`WD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire watchdog_pkg::reg_byte_t avs_writedata,
  input wire watchdog_pkg::reg_byte_t avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic oscClk,
  input wire logic vectorAck,
  input wire logic globalIrqEnable,
  input wire logic causeFlag,
  input wire logic alwaysOnFuse,
  input wire logic irqRequest,
  input wire logic sysResetReq
);
  import watchdog_pkg::*;
  logic oscQ_r, oscQ_nxt, rdDone, wrOne, calm;
  logic [4:0] age_r, age_nxt;
  // Cycles since the oscillator rose, saturating
  always_comb
  begin
    oscQ_nxt = oscClk;
    age_nxt = (oscClk && !oscQ_r) ? 5'h00 : age_r + {4'h0, age_r != 5'h1F};
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      oscQ_r <= 1'b0;
      age_r <= 5'h1F;
    end
    else
    begin
      oscQ_r <= oscQ_nxt;
      age_r <= age_nxt;
    end
  end
  assign rdDone = avs_read && !avs_waitrequest && avs_address == `WD_CSR_IDX;
  assign wrOne = avs_write && !avs_waitrequest && avs_address == `WD_CSR_IDX && avs_writedata[7];
  // Away from any time-out tick
  assign calm = age_r > 5'h06 && age_r < 5'h14;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  AST_IRQ_MASK: assert property (!globalIrqEnable |=> !irqRequest)
    else $error("irq while masked");
  AST_IRQ_FUSE: assert property (alwaysOnFuse [*3] |-> !irqRequest)
    else $error("irq under fuse");
  AST_CAUSE_FORCE: assert property (rdDone && $past(causeFlag) |-> avs_readdata[3])
    else $error("reset enable not forced");
  AST_FUSE_READ: assert property (rdDone && $past(alwaysOnFuse) |-> avs_readdata[3] && !avs_readdata[6])
    else $error("fuse lock not shown");
  AST_VEC_CLEAR: assert property (vectorAck && calm |-> ##2 !irqRequest)
    else $error("vector left irq");
  AST_WR1_CLEAR: assert property (wrOne && calm |-> ##2 !irqRequest)
    else $error("write one left irq");
  AST_TICK: assert property (sysResetReq |-> age_r < 5'h08)
    else $error("reset away from tick");
  AST_RST_PULSE: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset pulse too long");
endmodule
bind watchdog_timeout_unit watchdog_timeout_unit_assertions chk (.clk_sys, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .oscClk, .vectorAck, .globalIrqEnable,
  .causeFlag, .alwaysOnFuse, .irqRequest, .sysResetReq);

// ==== tb/watchdog_timeout_unit_bench.sv ====
/* Self-checking bench for the watchdog time-out unit.
   Assumes the unit, its package and checker are compiled first. */
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module watchdog_timeout_unit_bench;
  import watchdog_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, oscClk = 1'b0;
  logic restartPulse = 1'b0, vectorAck = 1'b0, globalIrqEnable = 1'b1, causeFlag = 1'b0;
  logic alwaysOnFuse = 1'b0, avs_waitrequest, irqRequest, sysResetReq;
  logic [`WD_ADDR_W-1:0] avs_address = 2'h0;
  reg_byte_t avs_writedata = 8'h00, avs_readdata, q;
  int num_errors = 0, num_checks = 0, cyc = 0, resets = 0, n0;
  watchdog_timeout_unit #(.BASE_PERIOD(4)) DUT (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .oscClk, .restartPulse, .vectorAck,
    .globalIrqEnable, .causeFlag, .alwaysOnFuse, .irqRequest, .sysResetReq);
  always #12.5 clk_sys = ~clk_sys;
  task tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task bad(input string m);
    num_errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  // Oscillator of 20 system clocks; count reset pulses
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9)
      oscClk <= ~oscClk;
    if (sysResetReq === 1'b1)
      resets <= resets + 1;
    if (cyc == 20000)
    begin
      bad("timeout");
      tally_and_finish();
    end
  end
  task bus(input logic w, input logic [1:0] a, input reg_byte_t d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input reg_byte_t d);
    bus(1'b1, 2'h0, d);
  endtask
  task rd(input logic [1:0] a, input reg_byte_t e);
    bus(1'b0, a, 8'h00);
    num_checks++;
    if (q !== e)
      bad($sformatf("read %h want %h", q, e));
  endtask
  task unlock(input reg_byte_t d);
    wr(8'h18);
    wr(d);
  endtask
  task pulse(input bit vec);
    @(posedge clk_sys);
    vectorAck <= vec;
    restartPulse <= !vec;
    @(posedge clk_sys);
    vectorAck <= 1'b0;
    restartPulse <= 1'b0;
  endtask
  task await(input bit onReset, input bit want);
    int n;
    n = 0;
    while ((onReset ? sysResetReq : irqRequest) !== 1'b1 && n < 300)
    begin
      @(posedge clk_sys);
      n++;
    end
    num_checks++;
    if ((n < 300) != want)
      bad("event seen or missed wrongly");
  endtask
  task sameResets();
    num_checks++;
    if (resets != n0)
      bad("unexpected reset");
  endtask
  task t_regs();
    rd(2'h0, 8'h00);
    bus(1'b1, 2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    wr(8'h08);
    wr(8'h01);
    rd(2'h0, 8'h08);
    wr(8'h18);
    rd(2'h0, 8'h18);
    rd(2'h0, 8'h08);
    unlock(8'h21);
    rd(2'h0, 8'h21);
    unlock(8'h2F);
    rd(2'h0, 8'h2F);
  endtask
  task t_irq();
    unlock(8'h40);
    pulse(1'b0);
    n0 = resets;
    await(1'b0, 1'b1);
    rd(2'h0, 8'hC0);
    wr(8'h40);
    rd(2'h0, 8'hC0);
    wr(8'hC0);
    rd(2'h0, 8'h40);
    globalIrqEnable <= 1'b0;
    await(1'b0, 1'b0);
    globalIrqEnable <= 1'b1;
    await(1'b0, 1'b1);
    pulse(1'b1);
    rd(2'h0, 8'h40);
    sameResets();
  endtask
  task t_comb();
    wr(8'hC8);
    pulse(1'b0);
    n0 = resets;
    await(1'b0, 1'b1);
    sameResets();
    pulse(1'b1);
    rd(2'h0, 8'h08);
    await(1'b1, 1'b1);
    // Let the reset counter take in the pulse just seen
    @(posedge clk_sys);
    n0 = resets;
    repeat (6)
    begin
      repeat (40) @(posedge clk_sys);
      pulse(1'b0);
    end
    sameResets();
    wr(8'h48);
    await(1'b0, 1'b1);
    await(1'b1, 1'b1);
  endtask
  task t_force();
    unlock(8'h80);
    n0 = resets;
    await(1'b0, 1'b0);
    sameResets();
    rd(2'h0, 8'h00);
    causeFlag <= 1'b1;
    rd(2'h0, 8'h08);
    unlock(8'h00);
    rd(2'h0, 8'h08);
    causeFlag <= 1'b0;
    alwaysOnFuse <= 1'b1;
    wr(8'h40);
    rd(2'h0, 8'h08);
    await(1'b1, 1'b1);
    alwaysOnFuse <= 1'b0;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_irq();
    t_comb();
    t_force();
    tally_and_finish();
  end
endmodule

// ==== verilog/osc_tick_sync.sv ====
/*
  Brings the low-frequency oscillator into the system clock domain and
  gives one pulse per oscillator rising edge.
  Assumes the oscillator is much slower than clk_sys.
*/
`timescale 1ns/1ps
module osc_tick_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic oscClk,
  output logic tick
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = sync_r & ~last_r;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      meta_r <= oscClk;
      sync_r <= meta_r;
      last_r <= sync_r;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// ==== verilog/watchdog_consts.svh ====
/*
  Constants of the watchdog time-out unit: register index, bit positions,
  reset values and counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// Register index (Avalon word address)
`define WD_CSR_IDX 2'h0
`define WD_ADDR_W 2

// Bit positions of supervisor_control_status
`define WD_BIT_IRQ_FLAG 7
`define WD_BIT_IRQ_ENABLE 6
`define WD_BIT_SEL_HI 5
`define WD_BIT_UNLOCK 4
`define WD_BIT_RESET_ENABLE 3
`define WD_SEL_LO_MSB 2

// Reset values
`define WD_CSR_RESET 8'h00
`define WD_SEL_RESET 4'h0
`define WD_READ_UNMAPPED 8'h00

// Time-out length: shortest period in oscillator cycles, largest legal code
`define WD_BASE_PERIOD 2048
`define WD_SEL_MAX 4'h9
`define WD_CNT_W 20
`define WD_OSC_FREQ_KHZ 128

// System clocks for which the change unlock stays set
`define WD_UNLOCK_CYCLES 3'h4

`endif

// ==== verilog/watchdog_pkg.sv ====
/*
  Types shared by the watchdog time-out unit.
  Assumes watchdog_consts.svh is on the include path.
*/
package watchdog_pkg;
  `include "watchdog_consts.svh"

  typedef logic [7:0] reg_byte_t;

  typedef logic [3:0] sel_code_t;

  // Stored control fields
  typedef struct packed {
    logic irqFlag;
    logic irqEnable;
    logic unlock;
    logic resetEnable;
    sel_code_t sel;
  } ctrl_t;

  // Bus answer phase, Gray coded
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
endpackage

// ==== verilog/watchdog_timeout_unit.sv ====
/*
  Watchdog time-out unit: oscillator cycle counter, time-out actions
  (interrupt, system reset, or both in turn), timed change unlock and the
  8-bit control/status register on an Avalon-MM slave.
  Assumes restart, vector acknowledge, global interrupt enable, reset-cause
  flag and always-on fuse come from logic on clk_sys; the oscillator is a pin.

// Summary of operation
// R1 - Software restarts counter before changing period
// R2 - Time-out in interrupt mode sets flag
// R3 - Vector execution clears the interrupt flag
// R4 - Writing one clears flag; zero ignored
// R5 - Request needs global enable, enable, flag
// R6 - Enable without reset enable: interrupt-only mode
// R7 - Combined mode: first time-out sets flag only
// R8 - Combined vector clears enable and flag
// R9 - Unserviced flag at next time-out resets
// R10 - Software re-enables interrupt after each service
// R11 - Reset-enable clear, select change need unlock
// R12 - Unlock self-clears after four system clocks
// R13 - Reset-cause flag forces reset enable set
// R14 - Select field: bit 5 high, bits 2..0
// R15 - Codes 0..9 give 2048 doubling to 1048576
// R16 - Stopped mode idle; reset-only mode resets
// R17 - Reserved select codes use longest period
// R18 - Counter counts 128 kHz oscillator cycles
// R19 - Restart instruction returns counter to zero
// R20 - Fuse locks reset-only: enable one, irq zero
// R21 - Unlock write, then settings within four clocks
*/
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module watchdog_timeout_unit #(
  parameter int BASE_PERIOD = `WD_BASE_PERIOD,
  parameter int CNT_W = `WD_CNT_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`WD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire watchdog_pkg::reg_byte_t avs_writedata,
  output watchdog_pkg::reg_byte_t avs_readdata,
  output logic avs_waitrequest,
  input wire logic oscClk,
  input wire logic restartPulse,
  input wire logic vectorAck,
  input wire logic globalIrqEnable,
  input wire logic causeFlag,
  input wire logic alwaysOnFuse,
  output logic irqRequest,
  output logic sysResetReq
);
  import watchdog_pkg::*;

  ctrl_t ctrl_r;
  ctrl_t ctrl_nxt;
  logic [2:0] unlockCnt_r;
  logic [2:0] unlockCnt_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  bus_state_t busSt_r;
  bus_state_t busSt_nxt;
  reg_byte_t rdata_r;
  reg_byte_t rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic rst_r;
  logic rst_nxt;

  logic oscTick;
  logic resetEnableEff;
  logic irqEnableEff;
  logic timeout;
  logic csrHit;
  logic wrAccept;
  logic flagSet;
  logic flagClear;
  reg_byte_t statusByte;

  // Last counter value of the selected period
  function automatic logic [CNT_W-1:0] periodLast(input sel_code_t sel);
    sel_code_t code;
    logic [31:0] span;
    code = (sel > `WD_SEL_MAX) ? `WD_SEL_MAX : sel; // R17
    span = 32'(BASE_PERIOD) << code; // R15
    periodLast = CNT_W'(span - 32'h1);
  endfunction

  // Oscillator rising edges become single clk_sys pulses
  osc_tick_sync oscSync ( // R18
    .clk_sys(clk_sys),
    .nrst(nrst),
    .oscClk(oscClk),
    .tick(oscTick)
  );

  always_comb
  begin
    resetEnableEff = ctrl_r.resetEnable | causeFlag | alwaysOnFuse; // R13 R20
    irqEnableEff = ctrl_r.irqEnable & ~alwaysOnFuse; // R20
    // Compare with >= so a shorter period chosen late fires at the next oscillator tick
    timeout = oscTick && (cnt_r >= periodLast(ctrl_r.sel));
    csrHit = (avs_address == `WD_CSR_IDX);
    wrAccept = avs_write && (busSt_r == BUS_ACK) && csrHit;
    statusByte = {ctrl_r.irqFlag, irqEnableEff, ctrl_r.sel[3], ctrl_r.unlock, // R14
                  resetEnableEff, ctrl_r.sel[2:0]};
  end

  // Bus slave: one wait cycle, answer at the second edge
  always_comb
  begin
    busSt_nxt = BUS_IDLE;
    rdata_nxt = rdata_r;
    case (busSt_r)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          busSt_nxt = BUS_ACK;
        end
        if (avs_read)
        begin
          rdata_nxt = csrHit ? statusByte : `WD_READ_UNMAPPED;
        end
      end
      BUS_ACK:
      begin
        busSt_nxt = BUS_IDLE;
      end
      default:
      begin
        busSt_nxt = BUS_IDLE;
      end
    endcase
  end

  assign avs_waitrequest = (avs_read || avs_write) && (busSt_r != BUS_ACK);
  assign avs_readdata = rdata_r;

  // Counter
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (restartPulse || timeout) // R19
    begin
      cnt_nxt = '0;
    end
    else if (oscTick) // R18
    begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  // Time-out actions, interrupt flag and enable
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    unlockCnt_nxt = unlockCnt_r;
    // Flag is set on time-out whenever interrupt operation is configured
    flagSet = timeout && irqEnableEff; // R2 R6 R7
    flagClear = vectorAck; // R3
    if (wrAccept && avs_writedata[`WD_BIT_IRQ_FLAG])
    begin
      flagClear = 1'b1; // R4
    end
    // Set wins over clear
    ctrl_nxt.irqFlag = flagSet | (ctrl_r.irqFlag & ~flagClear);

    rst_nxt = 1'b0;
    if (timeout && resetEnableEff)
    begin
      // Reset only: reset at once; combined: reset only if unserviced
      if (!irqEnableEff || ctrl_r.irqFlag) // R9 R16
      begin
        rst_nxt = 1'b1;
      end
    end

    if (wrAccept)
    begin
      ctrl_nxt.irqEnable = avs_writedata[`WD_BIT_IRQ_ENABLE];
    end
    if (vectorAck && resetEnableEff)
    begin
      ctrl_nxt.irqEnable = 1'b0; // R8
    end
    if (alwaysOnFuse)
    begin
      ctrl_nxt.irqEnable = 1'b0; // R20
    end

    // Reset enable and select: setting is free, the rest needs unlock
    if (wrAccept)
    begin
      if (ctrl_r.unlock) // R11
      begin
        ctrl_nxt.resetEnable = avs_writedata[`WD_BIT_RESET_ENABLE];
        ctrl_nxt.sel = {avs_writedata[`WD_BIT_SEL_HI], avs_writedata[`WD_SEL_LO_MSB:0]}; // R14
      end
      else
      begin
        ctrl_nxt.resetEnable = ctrl_r.resetEnable | avs_writedata[`WD_BIT_RESET_ENABLE];
      end
    end
    if (causeFlag || alwaysOnFuse)
    begin
      ctrl_nxt.resetEnable = 1'b1; // R13 R20
    end

    // Unlock opens on a write of one to both unlock and reset enable
    if (wrAccept && avs_writedata[`WD_BIT_UNLOCK] && avs_writedata[`WD_BIT_RESET_ENABLE]) // R11
    begin
      ctrl_nxt.unlock = 1'b1;
      unlockCnt_nxt = `WD_UNLOCK_CYCLES;
    end
    else if (ctrl_r.unlock)
    begin
      unlockCnt_nxt = unlockCnt_r - 3'h1;
      if (unlockCnt_r == 3'h1) // R12
      begin
        ctrl_nxt.unlock = 1'b0;
      end
    end

    irq_nxt = globalIrqEnable && irqEnableEff && ctrl_r.irqFlag; // R5
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= ctrl_t'(`WD_CSR_RESET);
      unlockCnt_r <= 3'h0;
      cnt_r <= '0;
      busSt_r <= BUS_IDLE;
      rdata_r <= `WD_READ_UNMAPPED;
      irq_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      unlockCnt_r <= unlockCnt_nxt;
      cnt_r <= cnt_nxt;
      busSt_r <= busSt_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      rst_r <= rst_nxt;
    end
  end

  assign irqRequest = irq_r;
  assign sysResetReq = rst_r;
endmodule
